// ==== shared/psl_pkg.sv ====
// shared constants, types and register map of the strap/led/power block
package psl_pkg;
  // clock rate and derived timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned BLINK_MS = 50;
  localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
  localparam int unsigned NLP_TX_UNIT_MS = 256;
  localparam int unsigned NLP_TX_UNIT_CYC = CLK_HZ / 1000 * NLP_TX_UNIT_MS;
  localparam int unsigned NLP_RX_UNIT_MS = 64;
  localparam int unsigned NLP_RX_UNIT_CYC = CLK_HZ / 1000 * NLP_RX_UNIT_MS;
  // least length of the automatic core reset, rounded up
  localparam int unsigned AUTO_RST_NS = 200;
  localparam int unsigned AUTO_RST_CYC = (AUTO_RST_NS + CLK_NS - 1) / CLK_NS;

  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;

  // status field positions
  localparam int ST_ENERGY = 0;
  localparam int ST_EVENT = 1;
  localparam int ST_REG_OFF = 2;
  localparam int ST_IRQSEL = 3;
  localparam int ST_RMII = 4;
  localparam int ST_EEE_ACT = 5;
  localparam int ST_EEE_CAP = 6;
  localparam int ST_CORE_ON = 7;

  // synchroniser reset pattern: shared pin and irq select idle high
  localparam logic [5:0] PIN_RST = 6'h28;

  // control register: power down and isolate
  typedef struct packed {
    logic isolate;
    logic power_down;
  } psl_ctrl_s;
  localparam psl_ctrl_s CTRL_RST = 2'h0;

  // energy-detect, link pulse and eee configuration
  typedef struct packed {
    logic eee_adv;
    logic eee_enable_bit;
    logic [1:0] rx_int_sel;
    logic single_wake;
    logic [1:0] tx_int_sel;
    logic nlp_tx_en;
    logic energy_detect_pd_enable;
  } psl_cfg_s;
  localparam psl_cfg_s CFG_RST = 9'h000;

  typedef enum logic [1:0] {PW_RUN, PW_GEN_PD, PW_WAKE_RST,
                            PW_ED_PD} psl_pwr_e;
endpackage

// ==== rtl/psl_sync.sv ====
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module psl_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  // first stage is read only by the second
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule

// ==== rtl/psl_timer.sv ====
// free interval timer: one-cycle tick every limit cycles while run
`timescale 1ns/1ps
module psl_timer #(
  parameter int CW = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [CW-1:0] limit,
  output logic tick
);
  logic [CW-1:0] cnt_ff;

  // restart from zero whenever run drops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= '0;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_ff <= '0;
      tick <= 1'b0;
    end else if (cnt_ff + 1'b1 >= limit) begin
      cnt_ff <= '0;
      tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule

// ==== rtl/psl_ctrl.sv ====
// straps, status leds, power-down modes and eee qualification
// Notes on behaviour
// - regulator-off strap sampled once when supplies are good; high disables.
// - floating regulator-off strap reads low; regulator stays enabled.
// - irq select strap latched at power-on and each hw reset rise.
// - shared pin is irq output or tx error input, by irq select strap.
// - link led on with valid link, blinking while carrier sense high.
// - speed led on at 100 Mbps, off at 10 Mbps or isolated.
// - link led active low if regulator-off strap high, else active high.
// - speed led active low if irq select strap high, else active high.
// - power-down bit set keeps all but management powered down.
// - clearing power-down powers up then auto-resets the transceiver.
// - energy-detect mode without energy powers down all but squelch logic.
// - no transmit while energy flag low; pulse or packet wakes, restores.
// - wake raises interrupt only if energy interrupt is unmasked.
// - energy-detect enable low means no energy-detect power-down.
// - idle-pulse transmit enabled sends link pulses at selected interval.
// - wake on one pulse, or two pulses within selected window.
// - eee has its own enable bit, reset to disabled.
// - eee only in mii, tx-error pin mode, enabled, advertised, 100 full.
// - eee capability and advertisement defaults follow eee enable.
// - isolate bit ignores transmit inputs, management still answers.
`timescale 1ns/1ps
module psl_ctrl #(
  parameter int unsigned BLINK_CYC = psl_pkg::BLINK_CYC,
  parameter int unsigned NLP_TX_UNIT = psl_pkg::NLP_TX_UNIT_CYC,
  parameter int unsigned NLP_RX_UNIT = psl_pkg::NLP_RX_UNIT_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hw_reset_n_pin,
  input wire logic supply_good,
  input wire logic regulator_off_strap,
  input wire logic irq_pin_select_strap,
  input wire logic reduced_mii_select_strap,
  input wire logic shared_pin_in,
  input wire logic link_valid,
  input wire logic carrier_sense,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic rx_energy,
  input wire logic rx_link_pulse,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic regulator_enable,
  output logic link_activity_led,
  output logic speed_led,
  output logic irq_out_n,
  output logic irq_pin_oe_n,
  output logic tx_error_in,
  output logic core_power_on,
  output logic squelch_power_on,
  output logic core_reset,
  output logic core_tx_enable,
  output logic nlp_tx_pulse,
  output logic eee_active
);
  logic [5:0] pin_q;
  logic hw_rst_n_s, supply_s, reg_off_s, irqsel_s, rmii_s, shared_s;
  logic hw_rst_n_d_ff, por_done_ff, reg_sampled_ff;
  logic reg_off_ff, irq_sel_ff, rmii_ff;
  psl_pkg::psl_ctrl_s ctrl_ff;
  psl_pkg::psl_cfg_s cfg_ff;
  logic irq_mask_ff, energy_flag_ff, energy_event_ff;
  psl_pkg::psl_pwr_e state_ff, nxt_state;
  logic [2:0] rst_cnt_ff;
  logic armed_ff, wake;
  logic [31:0] win_cnt_ff;
  logic blink_tick, blink_ff, nlp_tick;
  logic hw_rst_rise, wr_status, evt_clear;
  logic [15:0] nxt_rdata;

  // interval = unit * (select + 1)
  function automatic logic [31:0] interval(input int unsigned unit,
                                           input logic [1:0] sel);
    interval = 32'(unit * (32'(sel) + 32'd1));
  endfunction

  // all pins pass two flip-flops first
  psl_sync #(.W(6), .RST_VAL(psl_pkg::PIN_RST)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({shared_pin_in, reduced_mii_select_strap, irq_pin_select_strap,
        regulator_off_strap, supply_good, hw_reset_n_pin}),
    .q(pin_q)
  );
  assign {shared_s, rmii_s, irqsel_s, reg_off_s, supply_s, hw_rst_n_s}
    = pin_q;
  assign hw_rst_rise = hw_rst_n_s && !hw_rst_n_d_ff;

  // hw reset pin edge history and power-on marker
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hw_rst_n_d_ff <= 1'b0;
      por_done_ff <= 1'b0;
    end else begin
      hw_rst_n_d_ff <= hw_rst_n_s;
      por_done_ff <= 1'b1;
    end
  end

  // regulator strap caught once, after supplies are good
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_sampled_ff <= 1'b0;
      reg_off_ff <= 1'b0; // pull-down default keeps regulator on
    end else if (supply_s && !reg_sampled_ff) begin
      reg_sampled_ff <= 1'b1;
      reg_off_ff <= reg_off_s;
    end
  end

  // mode straps at power-on and on each hw reset release, else held
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_sel_ff <= 1'b1; // pull-up: interrupt mode
      rmii_ff <= 1'b0;
    end else if (!por_done_ff || hw_rst_rise) begin
      irq_sel_ff <= irqsel_s;
      rmii_ff <= rmii_s;
    end
  end

  // regulator output follows the sampled strap
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) regulator_enable <= 1'b1;
    else regulator_enable <= !reg_off_ff;
  end

  assign wr_status = reg_wr && reg_addr == psl_pkg::OFS_STATUS;
  assign evt_clear = wr_status && reg_wdata[psl_pkg::ST_EVENT];

  // software registers; advertisement reloads from eee enable on reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff <= psl_pkg::CTRL_RST;
      cfg_ff <= psl_pkg::CFG_RST;
      irq_mask_ff <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == psl_pkg::OFS_CTRL) begin
        ctrl_ff <= psl_pkg::psl_ctrl_s'(reg_wdata[1:0]);
      end else if (reg_wr && reg_addr == psl_pkg::OFS_CFG) begin
        cfg_ff <= psl_pkg::psl_cfg_s'(reg_wdata[8:0]);
      end else if (reg_wr && reg_addr == psl_pkg::OFS_MASK) begin
        irq_mask_ff <= reg_wdata[0];
      end else if (core_reset) begin
        cfg_ff.eee_adv <= cfg_ff.eee_enable_bit;
      end
    end
  end

  // read mux, answered one cycle after the strobe
  always_comb begin
    nxt_rdata = 16'h0000;
    if (reg_addr == psl_pkg::OFS_CTRL) begin
      nxt_rdata[1:0] = ctrl_ff;
    end else if (reg_addr == psl_pkg::OFS_CFG) begin
      nxt_rdata[8:0] = cfg_ff;
    end else if (reg_addr == psl_pkg::OFS_STATUS) begin
      nxt_rdata[psl_pkg::ST_ENERGY] = energy_flag_ff;
      nxt_rdata[psl_pkg::ST_EVENT] = energy_event_ff;
      nxt_rdata[psl_pkg::ST_REG_OFF] = reg_off_ff;
      nxt_rdata[psl_pkg::ST_IRQSEL] = irq_sel_ff;
      nxt_rdata[psl_pkg::ST_RMII] = rmii_ff;
      nxt_rdata[psl_pkg::ST_EEE_ACT] = eee_active;
      nxt_rdata[psl_pkg::ST_EEE_CAP] = cfg_ff.eee_enable_bit;
      nxt_rdata[psl_pkg::ST_CORE_ON] = core_power_on;
    end else if (reg_addr == psl_pkg::OFS_MASK) begin
      nxt_rdata[0] = irq_mask_ff;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) reg_rdata <= 16'h0000;
    else if (reg_rd) reg_rdata <= nxt_rdata;
    else reg_rdata <= 16'h0000;
  end

  // two-pulse wake window; a pulse outside the window re-arms
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      armed_ff <= 1'b0;
      win_cnt_ff <= '0;
    end else if (state_ff != psl_pkg::PW_ED_PD || wake) begin
      armed_ff <= 1'b0;
      win_cnt_ff <= '0;
    end else if (rx_link_pulse) begin
      armed_ff <= 1'b1;
      win_cnt_ff <= '0;
    end else if (armed_ff) begin
      if (win_cnt_ff + 32'd1 >= interval(NLP_RX_UNIT, cfg_ff.rx_int_sel))
        armed_ff <= 1'b0;
      win_cnt_ff <= win_cnt_ff + 32'd1;
    end
  end

  // wake on packet energy, one pulse, or two within the window
  always_comb begin
    wake = 1'b0;
    if (state_ff == psl_pkg::PW_ED_PD) begin
      if (rx_energy) wake = 1'b1;
      else if (rx_link_pulse && cfg_ff.single_wake) wake = 1'b1;
      else if (rx_link_pulse && armed_ff) wake = 1'b1;
    end
  end

  // power state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      psl_pkg::PW_RUN: begin
        if (ctrl_ff.power_down) nxt_state = psl_pkg::PW_GEN_PD;
        else if (cfg_ff.energy_detect_pd_enable && !rx_energy)
          nxt_state = psl_pkg::PW_ED_PD;
      end
      psl_pkg::PW_GEN_PD: begin
        if (!ctrl_ff.power_down) nxt_state = psl_pkg::PW_WAKE_RST;
      end
      psl_pkg::PW_WAKE_RST: begin
        if (rst_cnt_ff == 3'(psl_pkg::AUTO_RST_CYC - 1))
          nxt_state = psl_pkg::PW_RUN;
      end
      psl_pkg::PW_ED_PD: begin
        if (ctrl_ff.power_down) nxt_state = psl_pkg::PW_GEN_PD;
        else if (!cfg_ff.energy_detect_pd_enable)
          nxt_state = psl_pkg::PW_RUN;
        else if (wake) nxt_state = psl_pkg::PW_WAKE_RST;
      end
      default: nxt_state = psl_pkg::PW_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) state_ff <= psl_pkg::PW_RUN;
    else state_ff <= nxt_state;
  end

  // length of the automatic reset after power-up
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) rst_cnt_ff <= 3'h0;
    else if (state_ff == psl_pkg::PW_WAKE_RST) rst_cnt_ff <= rst_cnt_ff + 3'h1;
    else rst_cnt_ff <= 3'h0;
  end

  // power and reset outputs; registers survive, so prior state is restored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_power_on <= 1'b1;
      squelch_power_on <= 1'b1;
      core_reset <= 1'b0;
      core_tx_enable <= 1'b0;
    end else begin
      core_power_on <= nxt_state == psl_pkg::PW_RUN
                    || nxt_state == psl_pkg::PW_WAKE_RST;
      squelch_power_on <= nxt_state != psl_pkg::PW_GEN_PD;
      core_reset <= nxt_state == psl_pkg::PW_WAKE_RST;
      core_tx_enable <= nxt_state == psl_pkg::PW_RUN
                     && !ctrl_ff.isolate;
    end
  end

  // energy flag and sticky wake event; a new wake beats the clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      energy_flag_ff <= 1'b0;
      energy_event_ff <= 1'b0;
    end else begin
      if (wake) energy_flag_ff <= 1'b1;
      else if (state_ff == psl_pkg::PW_ED_PD) energy_flag_ff <= 1'b0;
      else energy_flag_ff <= rx_energy;
      if (wake) energy_event_ff <= 1'b1;
      else if (evt_clear) energy_event_ff <= 1'b0;
    end
  end

  // idle link pulses only in energy-detect power-down
  psl_timer #(.CW(32)) u_nlp (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(state_ff == psl_pkg::PW_ED_PD && cfg_ff.nlp_tx_en),
    .limit(interval(NLP_TX_UNIT, cfg_ff.tx_int_sel)),
    .tick(nlp_tick)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) nlp_tx_pulse <= 1'b0;
    else nlp_tx_pulse <= nlp_tick && state_ff == psl_pkg::PW_ED_PD;
  end

  // blink phase runs only while carrier is seen
  psl_timer #(.CW(32)) u_blink (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(carrier_sense),
    .limit(32'(BLINK_CYC)),
    .tick(blink_tick)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) blink_ff <= 1'b0;
    else if (!carrier_sense) blink_ff <= 1'b0;
    else if (blink_tick) blink_ff <= !blink_ff;
  end

  // leds: xor with the strap gives the polarity
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_activity_led <= 1'b0;
      speed_led <= 1'b1;
    end else begin
      link_activity_led <= (link_valid && !blink_ff) ^ reg_off_ff;
      speed_led <= (speed_100 && !ctrl_ff.isolate && link_valid)
                 ^ irq_sel_ff;
    end
  end

  // shared pin: open interrupt driver or transmit error input
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_out_n <= 1'b1;
      irq_pin_oe_n <= 1'b1;
      tx_error_in <= 1'b0;
    end else begin
      irq_pin_oe_n <= !irq_sel_ff;
      irq_out_n <= !(irq_sel_ff && energy_event_ff && irq_mask_ff);
      tx_error_in <= !irq_sel_ff && !ctrl_ff.isolate && shared_s;
    end
  end

  // eee qualifies only with every condition in place
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) eee_active <= 1'b0;
    else eee_active <= !rmii_ff && !irq_sel_ff && cfg_ff.eee_enable_bit
                    && cfg_ff.eee_adv && speed_100 && full_duplex
                    && link_valid && state_ff == psl_pkg::PW_RUN;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_gen_pd_off: assert property (
    ctrl_ff.power_down [*4] |-> !core_power_on)
    else $error("core powered during general power-down");
  a_pd_exit_reset: assert property (
    state_ff == psl_pkg::PW_GEN_PD && !ctrl_ff.power_down |-> ##1 core_reset)
    else $error("no auto reset after power-down exit");
  a_ed_pd_no_tx: assert property (
    state_ff == psl_pkg::PW_ED_PD |-> !core_tx_enable)
    else $error("transmit enabled in energy-detect power-down");
  a_ed_pd_disabled: assert property (
    !cfg_ff.energy_detect_pd_enable |=> state_ff != psl_pkg::PW_ED_PD)
    else $error("energy-detect power-down while disabled");
  a_single_wake: assert property (
    state_ff == psl_pkg::PW_ED_PD && cfg_ff.single_wake && rx_link_pulse
    && cfg_ff.energy_detect_pd_enable && !ctrl_ff.power_down
    |=> state_ff == psl_pkg::PW_WAKE_RST)
    else $error("single pulse did not wake");
  a_irq_masked: assert property (
    !irq_out_n |-> $past(irq_mask_ff) && $past(energy_event_ff))
    else $error("interrupt without unmasked energy event");
  a_strap_hold: assert property (
    por_done_ff && !hw_rst_rise |=> $stable(irq_sel_ff) && $stable(rmii_ff))
    else $error("strap changed without reset");
  a_reg_off_once: assert property (
    reg_sampled_ff |=> $stable(reg_off_ff)
    ##1 regulator_enable == !reg_off_ff)
    else $error("regulator strap not held");
  a_eee_qualify: assert property (
    eee_active |-> !$past(rmii_ff) && !$past(irq_sel_ff)
    && $past(full_duplex))
    else $error("eee active without qualification");
  a_speed_isolate: assert property (
    ctrl_ff.isolate [*2] |-> speed_led == $past(irq_sel_ff))
    else $error("speed led active while isolated");

  c_ed_pd_wake: cover property (
    state_ff == psl_pkg::PW_ED_PD ##1 state_ff == psl_pkg::PW_WAKE_RST);
  c_gen_pd_exit: cover property (
    state_ff == psl_pkg::PW_GEN_PD ##1 state_ff == psl_pkg::PW_WAKE_RST);
  c_eee_on: cover property (eee_active);
  c_irq_low: cover property (!irq_out_n);
endmodule

// ==== tb/psl_link_partner.sv ====
// link partner and mac side model: link pulses and the shared pin
`timescale 1ns/1ps
module psl_link_partner (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pulse_go,
  input wire logic [7:0] pulse_gap,
  input wire logic tx_err_drive,
  input wire logic irq_out_n,
  input wire logic irq_pin_oe_n,
  output logic rx_link_pulse,
  output logic shared_pin_in
);
  logic [7:0] gap_ff;
  logic pulse_ff;

  // one pulse at once, a second gap cycles later; zero gap sends one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_ff <= 8'h00;
      pulse_ff <= 1'b0;
    end else begin
      pulse_ff <= pulse_go | (gap_ff == 8'h01);
      if (pulse_go) begin
        gap_ff <= pulse_gap;
      end else if (gap_ff != 8'h00) begin
        gap_ff <= gap_ff - 8'h01;
      end
    end
  end

  // the block sees the registered pulse as its received link pulse
  assign rx_link_pulse = pulse_ff;
  // block owns the wire in irq mode, otherwise the mac's tx error
  assign shared_pin_in = irq_pin_oe_n ? tx_err_drive : irq_out_n;
endmodule

// ==== tb/psl_ctrl_tb_top.sv ====
// self-checking bench for the strap, led and power-down block
`timescale 1ns/1ps
module psl_ctrl_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hw_reset_n_pin = 1'b1;
  logic supply_good = 1'b0;
  logic regulator_off_strap = 1'b0;
  logic irq_pin_select_strap = 1'b1;
  logic reduced_mii_select_strap = 1'b0;
  logic link_valid = 1'b0, carrier_sense = 1'b0, speed_100 = 1'b0;
  logic full_duplex = 1'b0, rx_energy = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic pulse_go = 1'b0, tx_err_drive = 1'b0;
  logic [7:0] pulse_gap = 8'h00;
  logic shared_pin_in, rx_link_pulse, regulator_enable, link_activity_led;
  logic speed_led, irq_out_n, irq_pin_oe_n, tx_error_in, core_power_on;
  logic squelch_power_on, core_reset, core_tx_enable, nlp_tx_pulse;
  logic eee_active;
  logic [15:0] reg_rdata, rv;
  int fail_count = 0, compares = 0, cyc = 0, n, k;

  psl_ctrl #(.BLINK_CYC(8), .NLP_TX_UNIT(10), .NLP_RX_UNIT(10)) u_psl_ctrl (
    .clk(clk), .sys_rst(sys_rst), .hw_reset_n_pin(hw_reset_n_pin),
    .supply_good(supply_good), .regulator_off_strap(regulator_off_strap),
    .irq_pin_select_strap(irq_pin_select_strap),
    .reduced_mii_select_strap(reduced_mii_select_strap),
    .shared_pin_in(shared_pin_in),
    .link_valid(link_valid), .carrier_sense(carrier_sense),
    .speed_100(speed_100), .full_duplex(full_duplex),
    .rx_energy(rx_energy), .rx_link_pulse(rx_link_pulse),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .regulator_enable(regulator_enable),
    .link_activity_led(link_activity_led), .speed_led(speed_led),
    .irq_out_n(irq_out_n), .irq_pin_oe_n(irq_pin_oe_n),
    .tx_error_in(tx_error_in), .core_power_on(core_power_on),
    .squelch_power_on(squelch_power_on), .core_reset(core_reset),
    .core_tx_enable(core_tx_enable), .nlp_tx_pulse(nlp_tx_pulse),
    .eee_active(eee_active));

  psl_link_partner u_psl_link_partner (
    .clk(clk), .sys_rst(sys_rst), .pulse_go(pulse_go),
    .pulse_gap(pulse_gap), .tx_err_drive(tx_err_drive),
    .irq_out_n(irq_out_n), .irq_pin_oe_n(irq_pin_oe_n),
    .rx_link_pulse(rx_link_pulse), .shared_pin_in(shared_pin_in));

  // 50 ns clock
  initial begin
    forever #25 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // hang guard, the full run needs well under 3000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkb(input string what, input logic exp, input logic got);
    chk(what, {15'h0000, exp}, {15'h0000, got});
  endtask

  // wait n edges, then step past the edge so outputs have settled
  task automatic wt(input int cnt);
    repeat (cnt) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic pulses(input logic [7:0] g);
    @(posedge clk);
    pulse_go <= 1'b1;
    pulse_gap <= g;
    @(posedge clk);
    pulse_go <= 1'b0;
  endtask

  // cycles from one idle link pulse to the next
  task automatic gap(output int c);
    c = 0;
    k = 0;
    while (nlp_tx_pulse !== 1'b1 && k < 100) begin
      wt(1);
      k++;
    end
    wt(1);
    c = 1;
    while (nlp_tx_pulse !== 1'b1 && c < 200) begin
      wt(1);
      c++;
    end
  endtask

  // count cycles with core power up over a window
  task automatic up_cnt(input int w, output int c);
    c = 0;
    repeat (w) begin
      wt(1);
      if (core_power_on === 1'b1) c++;
    end
  endtask

  // pulse the hw reset pin so the mode straps are latched again
  task automatic hw_pulse();
    @(posedge clk);
    hw_reset_n_pin <= 1'b0;
    wt(5);
    @(posedge clk);
    hw_reset_n_pin <= 1'b1;
    wt(6);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    supply_good <= 1'b1;
    wt(6);
    chkb("reg_en", 1'b1, regulator_enable);
    rd(psl_pkg::OFS_CFG, rv);
    chk("cfg", 16'h0000, rv);
    rd(psl_pkg::OFS_CTRL, rv);
    chk("ctrl", 16'h0000, rv);
    rd(8'h10, rv);
    chk("unmapped", 16'h0000, rv);
    rd(psl_pkg::OFS_STATUS, rv);
    chk("status", 16'h0088, rv & 16'h00dc);
    chkb("oe_irq", 1'b0, irq_pin_oe_n);
    up_cnt(20, n);
    chk("no_ed_pd", 16'd20, n[15:0]);
    // led polarity with regulator strap low and irq strap high
    @(posedge clk);
    link_valid <= 1'b1;
    speed_100 <= 1'b1;
    wt(3);
    chkb("link_led", 1'b1, link_activity_led);
    chkb("spd_led", 1'b0, speed_led);
    @(posedge clk);
    carrier_sense <= 1'b1;
    n = 0;
    repeat (32) begin
      wt(1);
      if (link_activity_led === 1'b1) n++;
    end
    chkb("blink", 1'b1, n > 8 && n < 24);
    @(posedge clk);
    carrier_sense <= 1'b0;
    speed_100 <= 1'b0;
    wt(20);
    chkb("link_still", 1'b1, link_activity_led);
    chkb("spd_10", 1'b1, speed_led);
    @(posedge clk);
    speed_100 <= 1'b1;
    wr(psl_pkg::OFS_CTRL, 16'h0002);
    wt(3);
    chkb("spd_iso", 1'b1, speed_led);
    chkb("tx_iso", 1'b0, core_tx_enable);
    // general power-down, then wake with automatic reset
    wr(psl_pkg::OFS_CTRL, 16'h0001);
    wt(3);
    chkb("pd_core", 1'b0, core_power_on);
    chkb("pd_sq", 1'b0, squelch_power_on);
    wr(psl_pkg::OFS_CTRL, 16'h0000);
    wt(1);
    n = 0;
    while (core_reset === 1'b1 && n < 20) begin
      n++;
      wt(1);
    end
    chk("auto_rst", 16'(psl_pkg::AUTO_RST_CYC), n[15:0]);
    chkb("tx_back", 1'b1, core_tx_enable);
    // energy-detect power-down, idle pulses at each interval code
    wr(psl_pkg::OFS_MASK, 16'h0001);
    wr(psl_pkg::OFS_CFG, 16'h0013);
    wt(4);
    chkb("ed_core", 1'b0, core_power_on);
    chkb("ed_sq", 1'b1, squelch_power_on);
    chkb("ed_tx", 1'b0, core_tx_enable);
    for (int s = 0; s < 4; s++) begin
      wr(psl_pkg::OFS_CFG, 16'h0013 | 16'(s << 2));
      gap(n);
      gap(n);
      chk("nlp_gap", 16'(10 * (s + 1)), n[15:0]);
    end
    pulses(8'h00);
    up_cnt(4, n);
    chkb("wake1", 1'b1, n > 0);
    chkb("irq", 1'b0, irq_out_n);
    rd(psl_pkg::OFS_STATUS, rv);
    chk("event", 16'h0002, rv & 16'h0002);
    wr(psl_pkg::OFS_STATUS, 16'h0002);
    wr(psl_pkg::OFS_MASK, 16'h0000);
    wt(6);
    chkb("irq_clr", 1'b1, irq_out_n);
    pulses(8'h00);
    wt(4);
    chkb("irq_mask", 1'b1, irq_out_n);
    // two-pulse wake inside and outside the detect window
    wr(psl_pkg::OFS_CFG, 16'h0001);
    up_cnt(40, n);
    pulses(8'd15);
    up_cnt(40, n);
    chk("far_pair", 16'h0000, n[15:0]);
    pulses(8'd5);
    up_cnt(10, n);
    chkb("near_pair", 1'b1, n > 0);
    wr(psl_pkg::OFS_CFG, 16'h0061);
    up_cnt(40, n);
    pulses(8'd30);
    up_cnt(36, n);
    chkb("wide_pair", 1'b1, n > 0);
    @(posedge clk);
    rx_energy <= 1'b1;
    wt(8);
    chkb("pkt_wake", 1'b1, core_power_on);
    wr(psl_pkg::OFS_CFG, 16'h0000);
    // hardware reset relatches the irq strap low: tx error mode
    @(posedge clk);
    irq_pin_select_strap <= 1'b0;
    tx_err_drive <= 1'b1;
    hw_pulse();
    rd(psl_pkg::OFS_STATUS, rv);
    chk("irq_sel", 16'h0000, rv & 16'h0008);
    chkb("spd_hi", 1'b1, speed_led);
    chkb("oe_n", 1'b1, irq_pin_oe_n);
    chkb("tx_err", 1'b1, tx_error_in);
    @(posedge clk);
    irq_pin_select_strap <= 1'b1;
    wt(6);
    chkb("strap_hold", 1'b1, speed_led);
    // eee needs mii, tx error mode, enable, advert and 100 full
    @(posedge clk);
    full_duplex <= 1'b1;
    irq_pin_select_strap <= 1'b0;
    wr(psl_pkg::OFS_CFG, 16'h0180);
    wt(4);
    chkb("eee_on", 1'b1, eee_active);
    rd(psl_pkg::OFS_STATUS, rv);
    chk("eee_st", 16'h0060, rv & 16'h0060);
    // reduced mii strap refuses eee, plain mii brings it back
    @(posedge clk);
    reduced_mii_select_strap <= 1'b1;
    hw_pulse();
    chkb("eee_rmii", 1'b0, eee_active);
    @(posedge clk);
    reduced_mii_select_strap <= 1'b0;
    hw_pulse();
    chkb("eee_mii", 1'b1, eee_active);
    @(posedge clk);
    full_duplex <= 1'b0;
    wt(4);
    chkb("eee_half", 1'b0, eee_active);
    @(posedge clk);
    full_duplex <= 1'b1;
    wr(psl_pkg::OFS_CFG, 16'h0100);
    wt(4);
    chkb("eee_off", 1'b0, eee_active);
    // auto reset reloads the advert bit from the cleared enable
    wr(psl_pkg::OFS_CTRL, 16'h0001);
    wr(psl_pkg::OFS_CTRL, 16'h0000);
    wt(8);
    rd(psl_pkg::OFS_CFG, rv);
    chk("adv_reload", 16'h0000, rv);
    // second power-on with the regulator strap high
    @(posedge clk);
    sys_rst <= 1'b1;
    supply_good <= 1'b0;
    regulator_off_strap <= 1'b1;
    wt(4);
    @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    supply_good <= 1'b1;
    wt(6);
    chkb("reg_off", 1'b0, regulator_enable);
    chkb("led_lo", 1'b0, link_activity_led);
    @(posedge clk);
    regulator_off_strap <= 1'b0;
    wt(6);
    chkb("reg_hold", 1'b0, regulator_enable);
    give_verdict();
  end
endmodule
